// ===== verilog/dbpt_bank_sched.sv
`timescale 1ns/1ps
// Operation
// - write to precharge: WL+BL/2+write recovery
// - never precharge before write recovery ends
// - explicit precharge uses analog tWR, rounded
// - close active bank before opening another row
// - A10 low: bank stays open after burst
// - A10 high: auto close enabled
// - read auto close at AL+BL/2 edge
// - unmet tRAS or tRTP delays auto close
// - tRP counts from actual internal start
// - read auto close to activate: AL+(2)+tRTP+tRP
// - internal close two clocks after last prefetch
// - reactivate after tRP and tRC both
// - read close starts CL before burst end
// - write close after data, WR, tRAS
// - write auto close: tDAL and tRC
// - lockout delays auto close until restore
// - read to precharge: AL+BL/2+max(RTP,2)-2
// - read-precharge time rounded up to clocks
// - A10 high closes all, else one bank
// - precharges need one clock between them
module dbpt_bank_sched
    import dbpt_pkg::*;
#(
    parameter int AL = DEF_AL,
    parameter int CL = DEF_CL,
    parameter int BL = DEF_BL,
    parameter int WR = DEF_WR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire dbpt_op_e reqOp,
    input wire logic [BANK_W-1:0] reqBank,
    input wire logic reqAutoClose,
    output logic reqReady,
    output logic reqError,
    output logic issued,
    dbpt_cmd_if.ctrl link
);
    localparam int PF = (BL == 8) ? BL8_PREFETCH_OFS : 0;
    localparam int WL = AL + CL - 1;
    // spacings to the next legal edge, minus one for the countdown
    localparam logic [CNT_W-1:0] RD_PRE_M1 = CNT_W'(AL + BL / 2 + RTP2_CYC - 2 - 1);
    localparam logic [CNT_W-1:0] WR_PRE_M1 = CNT_W'(WL + BL / 2 + TWR_CYC - 1);
    localparam int RDAP_A = AL + PF + TRTP_CYC + TRP_CYC;
    localparam int RDAP_B = AL + BL / 2 + TRP_CYC;
    localparam int RDAP_C = AL + PF + AP_FLOOR_CYC + TRP_CYC;
    localparam int RDAP_AB = (RDAP_A > RDAP_B) ? RDAP_A : RDAP_B;
    localparam logic [CNT_W-1:0] RDAP_ACT_M1 = CNT_W'(((RDAP_AB > RDAP_C) ? RDAP_AB : RDAP_C) - 1);
    localparam logic [CNT_W-1:0] WRAP_ACT_M1 = CNT_W'(WL + BL / 2 + WR + TRP_CYC - 1);
    localparam logic [CNT_W-1:0] RAS_M1 = CNT_W'(TRAS_CYC - 1);
    localparam logic [CNT_W-1:0] RC_M1 = CNT_W'(TRC_CYC - 1);
    localparam logic [CNT_W-1:0] RP_M1 = CNT_W'(TRP_CYC - 1);
    localparam logic [CNT_W-1:0] RP_C = CNT_W'(TRP_CYC);

    if (!(BL == 4 || BL == 8) || AL > 6 || CL < 3 || CL > 7 || WR < 2 || WR > 8) begin : g_bad
        $error("dbpt_bank_sched: unsupported mode settings");
    end

    // every countdown must fit the counter, or a spacing wraps short
    if (WL + BL / 2 + WR + TRP_CYC >= (1 << CNT_W) || TRC_CYC >= (1 << CNT_W)) begin : g_narrow
        $error("dbpt_bank_sched: spacing too long for counters");
    end

    if (NUM_BANKS != (1 << BANK_W)) begin : g_banks
        $error("dbpt_bank_sched: bank count must match bank address width");
    end

    ////////////////////////////////////////////////////////////////////////
    // single pending slot; ready comes back one cycle after issue
    logic pend_reg;
    dbpt_op_e pOp_reg;
    logic [BANK_W-1:0] pBank_reg;
    logic pA10_reg;
    logic [NUM_BANKS-1:0] openVec;
    logic [NUM_BANKS-1:0] preZero;
    logic [NUM_BANKS-1:0] actZero;

    wire accept = reqValid && reqReady;
    wire isCol = pOp_reg == OP_READ || pOp_reg == OP_WRITE;
    wire curOpen = openVec[pBank_reg];
    wire curPreOk = preZero[pBank_reg];
    wire curActOk = actZero[pBank_reg];
    wire allPreOk = &preZero;
    wire badReq = pend_reg && ((pOp_reg == OP_ACT && curOpen) || (isCol && !curOpen));
    wire preOk = pA10_reg ? allPreOk : curPreOk;
    wire legal = (pOp_reg == OP_ACT) ? curActOk : ((pOp_reg == OP_PRE) ? preOk : 1'b1);
    wire issue = pend_reg && !badReq && legal;
    wire pendNext = accept ? 1'b1 : ((issue || badReq) ? 1'b0 : pend_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            pOp_reg <= OP_ACT;
            pBank_reg <= 3'h0;
            pA10_reg <= 1'b0;
        end else begin
            pend_reg <= pendNext;
            if (accept) begin
                pOp_reg <= reqOp;
                pBank_reg <= reqBank;
                pA10_reg <= reqAutoClose;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reqReady <= 1'b0;
            reqError <= 1'b0;
            issued <= 1'b0;
        end else begin
            reqReady <= !pendNext;
            reqError <= badReq;
            issued <= issue;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // precharge back to back needs no gap beyond the slot itself
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.cmdValid <= 1'b0;
            link.cmdOp <= OP_ACT;
            link.cmdBank <= 3'h0;
            link.cmdA10 <= 1'b0;
        end else begin
            link.cmdValid <= issue;
            link.cmdOp <= pOp_reg;
            link.cmdBank <= pBank_reg;
            link.cmdA10 <= pA10_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-bank countdowns: zero means the command may go this edge
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic [CNT_W-1:0] preBlk_reg;
        logic [CNT_W-1:0] actBlk_reg;
        logic open_reg;
        logic [CNT_W-1:0] preNext;
        logic [CNT_W-1:0] actNext;
        logic openNext;
        wire hit = issue && pBank_reg == BANK_W'(b);
        wire preHit = issue && pOp_reg == OP_PRE && (pA10_reg || pBank_reg == BANK_W'(b));
        wire [CNT_W-1:0] preDec = (preBlk_reg == 8'h00) ? 8'h00 : preBlk_reg - 8'h01;
        wire [CNT_W-1:0] actDec = (actBlk_reg == 8'h00) ? 8'h00 : actBlk_reg - 8'h01;
        // tRAS may hold the auto close, so tRP runs from that later start
        wire [CNT_W-1:0] rasThenRp = preDec + RP_C;
        // auto close loads, ras-limited start folded in
        wire [CNT_W-1:0] rdActLoad = cmax(RDAP_ACT_M1, rasThenRp);
        wire [CNT_W-1:0] wrActLoad = cmax(WRAP_ACT_M1, rasThenRp);

        assign openVec[b] = open_reg;
        assign preZero[b] = preBlk_reg == 8'h00;
        assign actZero[b] = actBlk_reg == 8'h00;

        always_comb begin
            preNext = preDec;
            actNext = actDec;
            openNext = open_reg;
            if (hit) begin
                case (pOp_reg)
                    OP_ACT: begin
                        preNext = RAS_M1;
                        actNext = RC_M1;
                        openNext = 1'b1;
                    end
                    OP_READ: begin
                        preNext = cmax(preDec, RD_PRE_M1);
                        if (pA10_reg) begin
                            actNext = cmax(actDec, rdActLoad);
                            openNext = 1'b0;
                        end
                    end
                    OP_WRITE: begin
                        preNext = cmax(preDec, WR_PRE_M1);
                        if (pA10_reg) begin
                            actNext = cmax(actDec, wrActLoad);
                            openNext = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            if (preHit && open_reg) begin
                actNext = cmax(actDec, RP_M1);
                openNext = 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                preBlk_reg <= 8'h00;
                actBlk_reg <= 8'h00;
                open_reg <= 1'b0;
            end else begin
                preBlk_reg <= preNext;
                actBlk_reg <= actNext;
                open_reg <= openNext;
            end
        end
    end
endmodule

// ===== shared/dbpt_pkg.sv
package dbpt_pkg;
    // clock and analog timing, picoseconds
    localparam int TCK_PS = 8000;
    localparam int TRAS_PS = 45000;
    localparam int TRP_PS = 12500;
    localparam int TRC_PS = 57500;
    localparam int TRTP_PS = 7500;
    localparam int TWR_PS = 15000;
    // least times round up to whole clocks
    localparam int TRAS_CYC = (TRAS_PS + TCK_PS - 1) / TCK_PS;
    localparam int TRP_CYC = (TRP_PS + TCK_PS - 1) / TCK_PS;
    localparam int TRC_CYC = (TRC_PS + TCK_PS - 1) / TCK_PS;
    localparam int TRTP_CYC = (TRTP_PS + TCK_PS - 1) / TCK_PS;
    localparam int TWR_CYC = (TWR_PS + TCK_PS - 1) / TCK_PS;
    localparam int RTP2_CYC = (TRTP_CYC > 2) ? TRTP_CYC : 2;
    // mode register defaults
    localparam int DEF_AL = 0;
    localparam int DEF_CL = 5;
    localparam int DEF_BL = 4;
    localparam int DEF_WR = 6;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int CNT_W = 8;
    localparam int BL8_PREFETCH_OFS = 2;
    localparam int AP_FLOOR_CYC = 2;

    typedef enum logic [1:0] {
        OP_ACT = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2,
        OP_PRE = 2'h3
    } dbpt_op_e;

    typedef enum logic [3:0] {
        BK_IDLE = 4'h1,
        BK_OPEN = 4'h2,
        BK_AUTO = 4'h4,
        BK_PRECH = 4'h8
    } dbpt_bank_e;

    function automatic logic [CNT_W-1:0] cmax(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
        cmax = (a > b) ? a : b;
    endfunction
endpackage

// ===== shared/dbpt_cmd_if.sv
`timescale 1ns/1ps
interface dbpt_cmd_if;
    import dbpt_pkg::*;
    logic cmdValid;
    dbpt_op_e cmdOp;
    logic [BANK_W-1:0] cmdBank;
    logic cmdA10;
    modport device(input cmdValid, input cmdOp, input cmdBank, input cmdA10);
    modport ctrl(output cmdValid, output cmdOp, output cmdBank, output cmdA10);
endinterface

// ===== verilog/dbpt_bank_timer.sv
`timescale 1ns/1ps
module dbpt_bank_timer
    import dbpt_pkg::*;
#(
    parameter int AL = DEF_AL,
    parameter int CL = DEF_CL,
    parameter int BL = DEF_BL,
    parameter int WR = DEF_WR
) (
    input wire logic clk,
    input wire logic rst_n,
    dbpt_cmd_if.device link,
    output logic [NUM_BANKS-1:0] bankOpen,
    output logic [NUM_BANKS-1:0] bankClosing,
    output logic [NUM_BANKS-1:0] closeStart,
    output logic [NUM_BANKS-1:0] cmdError
);
    localparam int PF = (BL == 8) ? BL8_PREFETCH_OFS : 0;
    localparam int WL = AL + CL - 1;
    localparam int RD_A = AL + BL / 2;
    localparam int RD_B = AL + PF + RTP2_CYC;
    localparam logic [CNT_W-1:0] RD_AP = CNT_W'((RD_A > RD_B) ? RD_A : RD_B);
    localparam logic [CNT_W-1:0] WR_AP = CNT_W'(WL + BL / 2 + WR);
    localparam logic [CNT_W-1:0] RAS_C = CNT_W'(TRAS_CYC);
    localparam logic [CNT_W-1:0] RP_C = CNT_W'(TRP_CYC);

    if (!(BL == 4 || BL == 8) || AL > 6 || CL < 3 || CL > 7 || WR < 2 || WR > 8) begin : g_bad
        $error("dbpt_bank_timer: unsupported mode settings");
    end

    ////////////////////////////////////////////////////////////////////////
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        dbpt_bank_e st_reg;
        dbpt_bank_e stNext;
        logic [CNT_W-1:0] ras_reg;
        logic [CNT_W-1:0] cnt_reg;
        logic [CNT_W-1:0] apLim_reg;
        wire hit = link.cmdValid && link.cmdBank == BANK_W'(b);
        wire actHit = hit && link.cmdOp == OP_ACT;
        wire rwHit = hit && (link.cmdOp == OP_READ || link.cmdOp == OP_WRITE);
        wire apHit = rwHit && link.cmdA10;
        wire preHit = link.cmdValid && link.cmdOp == OP_PRE && (link.cmdA10 || hit);
        wire rasMet = ras_reg >= RAS_C;
        // lockout: auto close waits for restore, so any column command may carry it
        wire apDue = cnt_reg >= apLim_reg && rasMet;
        wire rpDone = cnt_reg >= RP_C;
        wire errNext = (actHit && !(st_reg == BK_IDLE || (st_reg == BK_PRECH && rpDone)))
            || (rwHit && st_reg != BK_OPEN);

        always_comb begin
            stNext = st_reg;
            case (st_reg)
                BK_IDLE: if (actHit) stNext = BK_OPEN;
                BK_OPEN: begin
                    if (preHit) stNext = BK_PRECH;
                    else if (apHit) stNext = BK_AUTO;
                    else stNext = BK_OPEN;
                end
                BK_AUTO: if (apDue || preHit) stNext = BK_PRECH;
                BK_PRECH: if (rpDone) stNext = actHit ? BK_OPEN : BK_IDLE;
                default: stNext = BK_IDLE;
            endcase
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                st_reg <= BK_IDLE;
                ras_reg <= 8'h00;
            end else begin
                st_reg <= stNext;
                if (stNext == BK_OPEN && st_reg != BK_OPEN) ras_reg <= 8'h01;
                else if (!rasMet) ras_reg <= ras_reg + 8'h01;
            end
        end

        // tRP counts from the start itself, even when tRTP pushed it out
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cnt_reg <= 8'h00;
                apLim_reg <= 8'h00;
            end else begin
                if (stNext != st_reg) cnt_reg <= 8'h01;
                else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
                if (apHit) apLim_reg <= (link.cmdOp == OP_READ) ? RD_AP : WR_AP;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                bankOpen[b] <= 1'b0;
                bankClosing[b] <= 1'b0;
                closeStart[b] <= 1'b0;
                cmdError[b] <= 1'b0;
            end else begin
                bankOpen[b] <= stNext == BK_OPEN || stNext == BK_AUTO;
                bankClosing[b] <= stNext == BK_PRECH;
                closeStart[b] <= stNext == BK_PRECH && st_reg != BK_PRECH;
                cmdError[b] <= errNext;
            end
        end
    end
endmodule

// ===== test/dbpt_chk.sv
`timescale 1ns/1ps
module dbpt_chk
    import dbpt_pkg::*;
#(
    parameter int AL = DEF_AL,
    parameter int CL = DEF_CL,
    parameter int BL = DEF_BL,
    parameter int WR = DEF_WR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire dbpt_op_e cmdOp,
    input wire logic [BANK_W-1:0] cmdBank,
    input wire logic cmdA10
);
    localparam int WL = AL + CL - 1;
    localparam int PF = (BL == 8) ? BL8_PREFETCH_OFS : 0;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // ages saturate so old history never trips a check
    int agAct [NUM_BANKS];
    int agRd [NUM_BANKS];
    int agWr [NUM_BANKS];
    int agPre [NUM_BANKS];
    logic [NUM_BANKS-1:0] open_reg;
    logic [NUM_BANKS-1:0] rdAp_reg;
    logic [NUM_BANKS-1:0] wrAp_reg;
    wire isAct = cmdValid && cmdOp == OP_ACT;
    wire isRd = cmdValid && cmdOp == OP_READ;
    wire isWr = cmdValid && cmdOp == OP_WRITE;
    wire isPre = cmdValid && cmdOp == OP_PRE;
    wire [NUM_BANKS-1:0] sel = cmdValid ? (8'h01 << cmdBank) : 8'h00;
    wire [NUM_BANKS-1:0] preSel = (isPre && cmdA10) ? 8'hFF : (isPre ? sel : 8'h00);
    wire [NUM_BANKS-1:0] apSel = ((isRd || isWr) && cmdA10) ? sel : 8'h00;
    function automatic int age(input int a, input logic hit);
        return hit ? 0 : ((a < 999) ? a + 1 : 999);
    endfunction
    always_ff @(posedge clk) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            agAct[b] <= rst_n ? age(agAct[b], isAct && sel[b]) : 999;
            agRd[b] <= rst_n ? age(agRd[b], isRd && sel[b]) : 999;
            agWr[b] <= rst_n ? age(agWr[b], isWr && sel[b]) : 999;
            agPre[b] <= rst_n ? age(agPre[b], preSel[b] && open_reg[b]) : 999;
        end
    end
    always_ff @(posedge clk) begin
        open_reg <= rst_n ? ((open_reg | (isAct ? sel : 8'h00)) & ~preSel & ~apSel) : 8'h00;
        rdAp_reg <= rst_n ? ((rdAp_reg & ~(isAct ? sel : 8'h00)) | (isRd ? apSel : 8'h00)) : 8'h00;
        wrAp_reg <= rst_n ? ((wrAp_reg & ~(isAct ? sel : 8'h00)) | (isWr ? apSel : 8'h00)) : 8'h00;
    end
    ////////////////////////////////////////////////////////////
    AST_WR_TO_PRE: assert property (isPre && !cmdA10 |-> agWr[cmdBank] >= WL + BL / 2 + TWR_CYC - 1)
        else $error("precharge too soon after write");
    AST_RD_TO_PRE: assert property (isPre && !cmdA10 |-> agRd[cmdBank] >= AL + BL / 2 + RTP2_CYC - 3)
        else $error("precharge too soon after read");
    AST_ACT_CLOSED: assert property (isAct |-> !open_reg[cmdBank])
        else $error("activate to a bank still open");
    AST_RW_OPEN: assert property (isRd || isWr |-> open_reg[cmdBank])
        else $error("read or write to a bank not open");
    AST_RDAP_TO_ACT: assert property (isAct && rdAp_reg[cmdBank] |-> agRd[cmdBank] >= AL + PF + TRTP_CYC + TRP_CYC - 1)
        else $error("activate too soon after read with auto close");
    AST_WRAP_TO_ACT: assert property (isAct && wrAp_reg[cmdBank] |-> agWr[cmdBank] >= WL + BL / 2 + WR + TRP_CYC - 1)
        else $error("activate too soon after write with auto close");
    AST_ACT_TRC: assert property (isAct |-> agAct[cmdBank] >= TRC_CYC - 1)
        else $error("activate inside row cycle time");
    AST_PRE_TO_ACT: assert property (isAct |-> agPre[cmdBank] >= TRP_CYC - 1)
        else $error("activate inside precharge period");
    AST_CMD_PULSE: assert property ($rose(cmdValid) |=> !cmdValid)
        else $error("command strobe longer than one cycle");
endmodule

// ===== test/ddr2_bank_precharge_timing_tb.sv
`timescale 1ns/1ps
module ddr2_bank_precharge_timing_tb;
    import dbpt_pkg::*;
    localparam int WL = DEF_AL + DEF_CL - 1;
    localparam int PF = (DEF_BL == 8) ? BL8_PREFETCH_OFS : 0;
    localparam int RD_A = DEF_AL + DEF_BL / 2;
    localparam int RD_B = DEF_AL + PF + RTP2_CYC;
    localparam int RD_DUE = (RD_A > RD_B) ? RD_A : RD_B;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    dbpt_op_e reqOp = OP_ACT;
    logic [BANK_W-1:0] reqBank = 3'h0;
    logic reqAutoClose = 1'b0;
    logic reqReady;
    logic reqError;
    logic issued;
    logic [NUM_BANKS-1:0] bankOpen;
    logic [NUM_BANKS-1:0] bankClosing;
    logic [NUM_BANKS-1:0] closeStart;
    logic [NUM_BANKS-1:0] cmdError;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] rnd = 32'h0000E7B4;
    logic [6:0] expQ [$];
    logic [NUM_BANKS-1:0] openS = 8'h00;
    logic [NUM_BANKS-1:0] openD = 8'h00;
    int closeAt [NUM_BANKS] = '{default: -1};
    int closeEnd [NUM_BANKS] = '{default: 0};
    int actCyc [NUM_BANKS] = '{default: 0};
    // {op, bank, auto close}: spacing cases, refusals, close-all
    logic [5:0] dirTab [16] = '{6'h00, 6'h02, 6'h20, 6'h30, 6'h00, 6'h11, 6'h13, 6'h00,
        6'h21, 6'h00, 6'h10, 6'h10, 6'h00, 6'h14, 6'h31, 6'h12};
    dbpt_cmd_if link();
    dbpt_bank_sched dbpt_bank_sched_i (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
        .reqBank(reqBank), .reqAutoClose(reqAutoClose), .reqReady(reqReady), .reqError(reqError),
        .issued(issued), .link(link.ctrl));
    dbpt_bank_timer dbpt_bank_timer_i (.clk(clk), .rst_n(rst_n), .link(link.device), .bankOpen(bankOpen),
        .bankClosing(bankClosing), .closeStart(closeStart), .cmdError(cmdError));
    dbpt_chk #(.AL(DEF_AL), .CL(DEF_CL), .BL(DEF_BL), .WR(DEF_WR)) dbpt_chk_i (.clk(clk), .rst_n(rst_n),
        .cmdValid(link.cmdValid), .cmdOp(link.cmdOp), .cmdBank(link.cmdBank), .cmdA10(link.cmdA10));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // model of the bank view the scheduler must keep, updated at the take edge
    task automatic req(input logic [5:0] r);
        int n;
        logic err;
        n = 0;
        @(posedge clk);
        #1;
        reqValid = 1'b1;
        reqOp = dbpt_op_e'(r[5:4]);
        reqBank = r[3:1];
        reqAutoClose = r[0];
        do begin
            @(negedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 200);
        if (n >= 200) begin
            mismatches++;
        end
        @(posedge clk);
        err = (r[5:4] == 2'h0 && openS[r[3:1]]) || (r[5:4] inside {2'h1, 2'h2} && !openS[r[3:1]]);
        expQ.push_back({err, r});
        if (!err && r[5:4] == 2'h0) begin
            openS[r[3:1]] = 1'b1;
        end else if (!err && (r[0] || r[5:4] == 2'h3)) begin
            openS = (r[5:4] == 2'h3 && r[0]) ? 8'h00 : openS & ~(8'h01 << r[3:1]);
        end
        #1;
        reqValid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    // device model: closes are due in the cycle after the start edge
    always @(posedge clk) begin
        logic [NUM_BANKS-1:0] cs;
        logic [NUM_BANKS-1:0] cl;
        logic [6:0] e;
        int due;
        int bk;
        #2;
        cyc++;
        if (rst_n === 1'b1) begin
            check(issued, link.cmdValid);
            check(cmdError, 8'h00);
            if (issued === 1'b1 || reqError === 1'b1) begin
                e = (expQ.size() > 0) ? expQ.pop_front() : 7'h7F;
                check(reqError, e[6]);
                if (e[6] === 1'b0) begin
                    check({link.cmdOp, link.cmdBank, link.cmdA10}, e[5:0]);
                end
            end
            for (int b = 0; b < NUM_BANKS; b++) begin
                cs[b] = (closeAt[b] == cyc);
                closeEnd[b] = cs[b] ? cyc + TRP_CYC : closeEnd[b];
                cl[b] = (cyc < closeEnd[b]);
            end
            openD = openD & ~cs;
            check(closeStart, cs);
            check(bankOpen, openD);
            check(bankClosing, cl);
            if (link.cmdValid === 1'b1) begin
                bk = link.cmdBank;
                for (int b = 0; b < NUM_BANKS; b++) begin
                    if (link.cmdOp == OP_PRE && openD[b] && (link.cmdA10 || bk == b)) begin
                        closeAt[b] = cyc + 1;
                    end
                end
                if (link.cmdOp == OP_ACT) begin
                    openD[bk] = 1'b1;
                    actCyc[bk] = cyc;
                end else if (link.cmdOp != OP_PRE && link.cmdA10) begin
                    due = cyc + ((link.cmdOp == OP_READ) ? RD_DUE : WL + DEF_BL / 2 + DEF_WR);
                    due = (due < actCyc[bk] + TRAS_CYC) ? actCyc[bk] + TRAS_CYC : due;
                    closeAt[bk] = due + 1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        foreach (dirTab[i]) begin
            req(dirTab[i]);
        end
        // random mix on four banks, with idle gaps between requests
        repeat (300) begin
            rnd = lfsr(rnd);
            req({rnd[1:0], 1'b0, rnd[3:2], rnd[4]});
            repeat (rnd[6:5]) @(posedge clk);
        end
        repeat (40) @(posedge clk);
        check(expQ.size(), 32'h0);
        tally_and_finish();
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule
